//--- src/gsp_sector_protect.sv
// serial front end, write enable latch, status byte and register port
//
// Overview of operation
// - ones in bits 5..2 protect every sector
// - zeros in bits 5..2 unprotect every sector
// - mixed bits 5..2 leave sectors unchanged
// - only bit 7 stored, as lock bit
// - pin low, lock set: lock and sectors kept, latch cleared
// - pin high, lock set: only lock loads
// - lock clear: global decode and lock load
// - status bits 4..2 report pin and sectors
// - status write needs write enable latch set
// - reset leaves every sector protected
// - locked: sector commands ignored, latch cleared
// - hardware lock needs pin low and lock
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module gsp_sector_protect
    import gsp_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  sck,
    input  wire logic                  csN,
    input  wire logic                  si,
    input  wire logic                  wpN,
    output logic                       so,
    output logic                       soOeN,
    input  wire logic [REG_ADDR_W-1:0] regAddr,
    input  wire logic [REG_DATA_W-1:0] regWrData,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [REG_DATA_W-1:0] regRdData
);

    gsp_prot_if pif ();

    gsp_prot_core u_core (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pif     (pif)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; stage one feeds stage two only
    logic [3:0] pinA_q;
    logic [3:0] pinB_q;
    logic [1:0] edgeC_q;
    logic       sckS;
    logic       csNS;
    logic       siS;
    logic       wpNS;
    logic       sckRise;
    logic       sckFall;
    logic       csEnd;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinA_q  <= 4'hE;
            pinB_q  <= 4'hE;
            edgeC_q <= 2'h2;
        end else begin
            pinA_q  <= {wpN, csN, si, sck};
            pinB_q  <= pinA_q;
            edgeC_q <= {pinB_q[2], pinB_q[0]};
        end
    end

    assign sckS    = pinB_q[0];
    assign siS     = pinB_q[1];
    assign csNS    = pinB_q[2];
    assign wpNS    = pinB_q[3];
    assign sckRise = sckS && !edgeC_q[0];
    assign sckFall = !sckS && edgeC_q[0];
    assign csEnd   = csNS && !edgeC_q[1];

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] aggCode(input logic [SECT_NUM-1:0] s);
        if (&s) begin
            aggCode = AGG_ALL;
        end else if (|s) begin
            aggCode = AGG_SOME;
        end else begin
            aggCode = AGG_NONE;
        end
    endfunction

    logic                  wrLatch_q;
    logic [7:0]            status;

    always_comb begin
        status              = 8'h00;
        status[ST_LOCK]     = pif.lockBit;
        status[ST_PGM_ERR]  = 1'b0;     // no erase engine here, never flags
        status[ST_WP]       = wpNS;
        status[ST_AGG_HI:ST_AGG_LO] = aggCode(pif.sectors);
        status[ST_WR_LATCH] = wrLatch_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial command framing
    gsp_phase_t            phase_q;
    gsp_phase_t            phase_d;
    logic [2:0]            bitCnt_q;
    logic [2:0]            bitCnt_d;
    logic [1:0]            argCnt_q;
    logic [1:0]            argCnt_d;
    logic [7:0]            shift_q;
    logic [7:0]            shift_d;
    logic [7:0]            opcode_q;
    logic [7:0]            opcode_d;
    logic [7:0]            data_q;
    logic [7:0]            data_d;
    logic [23:0]           addr_q;
    logic [23:0]           addr_d;
    logic                  wrLatch_d;
    logic                  commit_q;
    logic                  commit_d;
    logic                  prot_q;
    logic                  prot_d;
    logic                  unprot_q;
    logic                  unprot_d;
    logic                  so_q;
    logic                  so_d;
    logic                  soOeN_q;
    logic                  soOeN_d;
    logic                  softRst_q;
    logic [7:0]            rxByte;

    always_comb begin
        phase_d  = phase_q;
        bitCnt_d = bitCnt_q;
        argCnt_d = argCnt_q;
        shift_d  = shift_q;
        opcode_d = opcode_q;
        data_d   = data_q;
        addr_d   = addr_q;
        wrLatch_d = wrLatch_q;
        commit_d = 1'b0;
        prot_d   = 1'b0;
        unprot_d = 1'b0;
        so_d     = so_q;
        soOeN_d  = soOeN_q;
        rxByte   = {shift_q[6:0], siS};
        if (csEnd && bitCnt_q == 3'h0 && phase_q == PH_ARGS) begin
            case (opcode_q)
                OP_WREN: begin
                    wrLatch_d = 1'b1;
                end
                OP_WRDI: begin
                    wrLatch_d = 1'b0;
                end
                OP_WRSR: begin
                    commit_d  = wrLatch_q && (argCnt_q != 2'h0);
                    wrLatch_d = 1'b0;
                end
                OP_PROT, OP_UNPROT: begin
                    // latch drops even when the core ignores a locked request
                    prot_d    = wrLatch_q && argCnt_q == ADDR_BYTES && opcode_q == OP_PROT;
                    unprot_d  = wrLatch_q && argCnt_q == ADDR_BYTES && opcode_q == OP_UNPROT;
                    wrLatch_d = 1'b0;
                end
                default: begin
                    wrLatch_d = wrLatch_q;
                end
            endcase
        end else if (csEnd && phase_q == PH_ARGS &&
                     (opcode_q == OP_PROT || opcode_q == OP_UNPROT)) begin
            wrLatch_d = 1'b0;
        end
        if (csNS) begin
            phase_d  = PH_OPCODE;
            bitCnt_d = 3'h0;
            argCnt_d = 2'h0;
            soOeN_d  = 1'b1;
        end else if (sckRise) begin
            shift_d  = rxByte;
            bitCnt_d = bitCnt_q + 3'h1;
            if (bitCnt_q == 3'h7) begin
                if (phase_q == PH_OPCODE) begin
                    opcode_d = rxByte;
                    phase_d  = PH_ARGS;
                end else if (argCnt_q != ADDR_BYTES) begin
                    addr_d   = {addr_q[15:0], rxByte};
                    argCnt_d = argCnt_q + 2'h1;
                    if (argCnt_q == 2'h0) begin
                        data_d = rxByte;
                    end
                end
            end
        end else if (sckFall && phase_q == PH_ARGS && opcode_q == OP_RDSR) begin
            so_d    = status[3'h7 - bitCnt_q];
            soOeN_d = 1'b0;
        end
        if (softRst_q) begin
            wrLatch_d = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase_q  <= PH_OPCODE;
            bitCnt_q <= 3'h0;
            argCnt_q <= 2'h0;
            shift_q  <= 8'h00;
            opcode_q <= 8'h00;
            data_q   <= 8'h00;
            addr_q   <= 24'h000000;
            wrLatch_q <= 1'b0;
            commit_q <= 1'b0;
            prot_q   <= 1'b0;
            unprot_q <= 1'b0;
            so_q     <= 1'b0;
            soOeN_q  <= 1'b1;
        end else begin
            phase_q  <= phase_d;
            bitCnt_q <= bitCnt_d;
            argCnt_q <= argCnt_d;
            shift_q  <= shift_d;
            opcode_q <= opcode_d;
            data_q   <= data_d;
            addr_q   <= addr_d;
            wrLatch_q <= wrLatch_d;
            commit_q <= commit_d;
            prot_q   <= prot_d;
            unprot_q <= unprot_d;
            so_q     <= so_d;
            soOeN_q  <= soOeN_d;
        end
    end

    assign pif.commit    = commit_q;
    assign pif.wrData    = data_q;
    assign pif.protReq   = prot_q;
    assign pif.unprotReq = unprot_q;
    assign pif.sectIdx   = addr_q[SECT_ADDR_LSB +: SECT_IDX_W];
    assign pif.softRst   = softRst_q;
    assign pif.wpN       = wpNS;
    assign so            = so_q;
    assign soOeN         = soOeN_q;

    ////////////////////////////////////////////////////////////////////////////////
    // register port: read data one cycle after the strobe
    logic [REG_DATA_W-1:0] rdData_q;
    logic [REG_DATA_W-1:0] rdData_d;
    logic                  softRst_d;

    always_comb begin
        rdData_d  = 8'h00;
        softRst_d = regWr && regAddr == REG_CTRL && regWrData[CTRL_RESET_BIT];
        if (regRd) begin
            case (regAddr)
                REG_STATUS:  rdData_d = status;
                REG_SECTORS: rdData_d = {{(REG_DATA_W-SECT_NUM){1'b0}}, pif.sectors};
                default:     rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData_q  <= 8'h00;
            softRst_q <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            softRst_q <= softRst_d;
        end
    end

    assign regRdData = rdData_q;

endmodule // gsp_sector_protect

//--- src/gsp_pkg.sv
// shared constants for the global sector protect decode block
package gsp_pkg;

    // register port
    localparam int          REG_ADDR_W     = 4;
    localparam int          REG_DATA_W     = 8;
    localparam logic [3:0]  REG_STATUS     = 4'h0;
    localparam logic [3:0]  REG_SECTORS    = 4'h4;
    localparam logic [3:0]  REG_CTRL       = 4'h8;
    localparam int          CTRL_RESET_BIT = 0;

    // sectors: 2 Mbit array in 64 kbyte sectors
    localparam int          SECT_NUM       = 4;
    localparam int          SECT_IDX_W     = 2;
    localparam int          SECT_ADDR_LSB  = 16;
    localparam logic [3:0]  SECT_RESET     = 4'hF;
    localparam logic        LOCK_RESET     = 1'b0;

    // status byte layout
    localparam int          ST_LOCK        = 7;
    localparam int          ST_PGM_ERR     = 5;
    localparam int          ST_WP          = 4;
    localparam int          ST_AGG_HI      = 3;
    localparam int          ST_AGG_LO      = 2;
    localparam int          ST_WR_LATCH    = 1;
    localparam int          ST_GLOBAL_HI   = 5;
    localparam int          ST_GLOBAL_LO   = 2;
    localparam logic [1:0]  AGG_NONE       = 2'h0;
    localparam logic [1:0]  AGG_SOME       = 2'h1;
    localparam logic [1:0]  AGG_ALL        = 2'h3;

    // serial opcodes
    localparam logic [7:0]  OP_WREN        = 8'h06;
    localparam logic [7:0]  OP_WRDI        = 8'h04;
    localparam logic [7:0]  OP_WRSR        = 8'h01;
    localparam logic [7:0]  OP_RDSR        = 8'h05;
    localparam logic [7:0]  OP_PROT        = 8'h36;
    localparam logic [7:0]  OP_UNPROT      = 8'h39;
    localparam logic [1:0]  ADDR_BYTES     = 2'h3;

    typedef enum logic [0:0] {
        PH_OPCODE = 1'b0,
        PH_ARGS   = 1'b1
    } gsp_phase_t;

endpackage : gsp_pkg

//--- src/gsp_prot_if.sv
// carrier between the serial front end and the protection core
`timescale 1ns/1ns
interface gsp_prot_if;
    import gsp_pkg::*;
    logic                  commit;
    logic [7:0]            wrData;
    logic                  protReq;
    logic                  unprotReq;
    logic [SECT_IDX_W-1:0] sectIdx;
    logic                  softRst;
    logic                  wpN;
    logic                  lockBit;
    logic [SECT_NUM-1:0]   sectors;

    modport front (output commit, wrData, protReq, unprotReq, sectIdx, softRst, wpN,
                   input lockBit, sectors);
    modport core  (input commit, wrData, protReq, unprotReq, sectIdx, softRst, wpN,
                   output lockBit, sectors);
endinterface : gsp_prot_if

//--- src/gsp_prot_core.sv
// protection lock bit, sector protection bits and global decode
`timescale 1ns/1ns
module gsp_prot_core
    import gsp_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    gsp_prot_if.core  pif
);

    logic                lock_q;
    logic                lock_d;
    logic [SECT_NUM-1:0] sect_q;
    logic [SECT_NUM-1:0] sect_d;
    logic                hwLock;
    logic [3:0]          globalBits;

    assign pif.lockBit = lock_q;
    assign pif.sectors = sect_q;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        lock_d     = lock_q;
        sect_d     = sect_q;
        hwLock     = !pif.wpN && lock_q;
        globalBits = pif.wrData[ST_GLOBAL_HI:ST_GLOBAL_LO];
        if (pif.softRst) begin
            sect_d = SECT_RESET;
            lock_d = LOCK_RESET;
        end else if (pif.commit) begin
            if (hwLock) begin
                lock_d = lock_q;
            end else if (lock_q) begin
                // soft lock: sectors frozen, lock may drop
                lock_d = pif.wrData[ST_LOCK];
            end else begin
                lock_d = pif.wrData[ST_LOCK];
                if (globalBits == 4'hF) begin
                    sect_d = {SECT_NUM{1'b1}};
                end else if (globalBits == 4'h0) begin
                    sect_d = {SECT_NUM{1'b0}};
                end else begin
                    sect_d = sect_q;
                end
            end
        end else if (!lock_q && pif.protReq) begin
            sect_d[pif.sectIdx] = 1'b1;
        end else if (!lock_q && pif.unprotReq) begin
            sect_d[pif.sectIdx] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_q <= LOCK_RESET;
            sect_q <= SECT_RESET;
        end else begin
            lock_q <= lock_d;
            sect_q <= sect_d;
        end
    end

endmodule // gsp_prot_core

//--- tb/gsp_host_model.sv
// host serial controller model, mode 0, msb first
`timescale 1ns/1ns
module gsp_host_model (
    output logic      sck,
    output logic      csN,
    output logic      si,
    input  wire logic so,
    input  wire logic soOeN
);
    // clock parks low between frames so no stray edge is seen
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b0;
    end
    // rd keeps the last eight bits seen on so
    task automatic frame(input logic [31:0] data, input int nbits, output logic [7:0] rd);
        // pin moves land on clk_sys edges: nonblocking keeps the sampling race-free
        rd = 8'h00;
        csN <= 1'b0;
        #200;
        for (int i = nbits - 1; i >= 0; i--) begin
            si <= data[i];
            #200 sck <= 1'b1;
            #100 rd = {rd[6:0], soOeN ? 1'bx : so};
            #100 sck <= 1'b0;
        end
        #200 csN <= 1'b1;
        // deselected: never leave the last bit standing
        si <= ~si;
        #400;
    endtask
endmodule // gsp_host_model

//--- tb/gsp_sector_protect_chk.sv
// port assertions for the sector protect block
`timescale 1ns/1ns
module gsp_sector_protect_chk
    import gsp_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       csN,
    input wire logic       wpN,
    input wire logic       soOeN,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData
);
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    // idle cycles since a frame or write; a commit lands well inside eight
    always_comb begin
        quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
        if (!csN || regWr)
            quiet_d = 4'h0;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            quiet_q <= 4'h0;
        else
            quiet_q <= quiet_d;
    end
    function automatic logic [1:0] aggOf(input logic [3:0] s);
        return (s == 4'hF) ? AGG_ALL : (s == 4'h0) ? AGG_NONE : AGG_SOME;
    endfunction
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_seRd; regRd && regAddr == REG_SECTORS; endsequence
    sequence s_stRd; regRd && regAddr == REG_STATUS; endsequence
    sequence s_clr; regWr && regAddr == REG_CTRL && regWrData[CTRL_RESET_BIT]; endsequence
    property p_rdIdle; !regRd |=> regRdData == 8'h00; endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
    property p_stFixed; s_stRd |=> !regRdData[ST_PGM_ERR] && !regRdData[0]; endproperty
    a_stFixed: assert property (p_stFixed) else $error("fixed status bit set");
    property p_aggSect;
        (quiet_q >= 4'h8 && regRd && regAddr == REG_SECTORS) ##1 s_stRd
            |=> regRdData[3:2] == aggOf($past(regRdData[3:0]));
    endproperty
    a_aggSect: assert property (p_aggSect) else $error("aggregate bits wrong");
    property p_wpEcho;
        regRd && regAddr == REG_STATUS && $past(wpN) == wpN && $past(wpN, 2) == wpN
            && $past(wpN, 4) == wpN |=> regRdData[ST_WP] == $past(wpN);
    endproperty
    a_wpEcho: assert property (p_wpEcho) else $error("pin level not shown");
    property p_quiet;
        (quiet_q >= 4'hA && regRd && regAddr == REG_STATUS) ##3 s_stRd
            |=> {regRdData[7], regRdData[3:1]} == {$past(regRdData[7], 3), $past(regRdData[3:1], 3)};
    endproperty
    a_quiet: assert property (p_quiet) else $error("state moved while idle");
    property p_oeIdle; csN [*5] |-> soOeN; endproperty
    a_oeIdle: assert property (p_oeIdle) else $error("output driven unselected");
    property p_oeSel; $fell(soOeN) |-> !csN; endproperty
    a_oeSel: assert property (p_oeSel) else $error("drive without select");
    property p_softRst; s_clr ##3 s_seRd |=> regRdData == {4'h0, SECT_RESET}; endproperty
    a_softRst: assert property (p_softRst) else $error("reset not protecting");
endmodule // gsp_sector_protect_chk
bind gsp_sector_protect gsp_sector_protect_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .csN(csN), .wpN(wpN), .soOeN(soOeN), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

//--- tb/tb_top.sv
// self-checking bench for the sector protect block
`timescale 1ns/1ns
module tb_top
    import gsp_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst, wpN, so, soOeN, sck, csN, si, regWr, regRd, lockM, latchM;
    logic [3:0]  regAddr, sectM;
    logic [7:0]  regWrData, regRdData, rx;
    logic [31:0] seed = 32'h4B35FF27;
    int          fail_count = 0;
    int          samples_checked = 0;
    // bit 8 is the pin level; the order walks every lock state
    logic [8:0]  tbl [11] = '{9'h100, 9'h17F, 9'h000, 9'h0FF, 9'h00F, 9'h100,
        9'h194, 9'h10F, 9'h100, 9'h1F0, 9'h17F};
    always #25 clk_sys = ~clk_sys;
    gsp_sector_protect dut (.clk_sys(clk_sys), .rst(rst), .sck(sck), .csN(csN), .si(si),
        .wpN(wpN), .so(so), .soOeN(soOeN), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
    gsp_host_model host (.sck(sck), .csN(csN), .si(si), .so(so), .soOeN(soOeN));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    function automatic logic [3:0] glob(input logic [7:0] d);
        if (d[5:2] == 4'hF)
            return 4'hF;
        return (d[5:2] == 4'h0) ? 4'h0 : sectM;
    endfunction
    function automatic logic [7:0] statExp();
        logic [1:0] agg;
        agg = (sectM == 4'hF) ? AGG_ALL : (sectM == 4'h0) ? AGG_NONE : AGG_SOME;
        return {lockM, 2'b00, wpN, agg, latchM, 1'b0};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // back to back reads: sectors then status
    task automatic rd_pair(output logic [7:0] se, output logic [7:0] st);
        regAddr <= REG_SECTORS;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regAddr <= REG_STATUS;
        @(negedge clk_sys) se = regRdData;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys) st = regRdData;
        @(posedge clk_sys);
    endtask
    task automatic verify(input string what);
        logic [7:0] se, st, r;
        repeat (2) begin
            rd_pair(se, st);
            check("sectors", se, {4'h0, sectM});
            check("status", st, statExp());
        end
        host.frame({16'h0, OP_RDSR, 8'h00}, 16, r);
        repeat (4) @(posedge clk_sys);
        check("serial status", r, statExp());
        $display("test %s done", what);
    endtask
    task automatic wrsr(input logic [7:0] d, input logic wp, input logic en);
        logic [7:0] r;
        wpN <= wp;
        repeat (6) @(posedge clk_sys);
        if (en)
            host.frame({24'h0, OP_WREN}, 8, r);
        host.frame({16'h0, OP_WRSR, d}, 16, r);
        repeat (4) @(posedge clk_sys);
        if (en && !(lockM && !wp)) begin
            if (!lockM)
                sectM = glob(d);
            lockM = d[ST_LOCK];
        end
        latchM = 1'b0;
        verify("status write");
    endtask
    task automatic sect_cmd(input logic [7:0] op, input logic [1:0] n);
        logic [7:0] r;
        host.frame({24'h0, OP_WREN}, 8, r);
        host.frame({op, 6'h0, n, 16'h0}, 32, r);
        repeat (4) @(posedge clk_sys);
        if (!lockM)
            sectM[n] = (op == OP_PROT);
        latchM = 1'b0;
        verify("sector command");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        wpN = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        lockM = LOCK_RESET;
        sectM = SECT_RESET;
        latchM = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (6) @(posedge clk_sys);
        verify("reset");
        wrsr(8'h00, 1'b1, 1'b0);
        // cut one bit short: no effect, latch kept
        host.frame({24'h0, OP_WREN}, 8, rx);
        host.frame({17'h0, OP_WRSR, 7'h00}, 15, rx);
        repeat (4) @(posedge clk_sys);
        latchM = 1'b1;
        verify("partial frame");
        // aligned disable drops the latch left standing above
        host.frame({24'h0, OP_WRDI}, 8, rx);
        repeat (4) @(posedge clk_sys);
        latchM = 1'b0;
        verify("write disable");
        foreach (tbl[i])
            wrsr(tbl[i][7:0], tbl[i][8], 1'b1);
        repeat (16) begin
            seed = xs(seed);
            rx = seed[12] ? tbl[seed[16:13] % 11][7:0] : seed[7:0];
            wrsr(rx, seed[8] | seed[9], seed[10] | seed[11]);
        end
        regAddr <= REG_CTRL;
        regWrData <= 8'h01;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        sectM = SECT_RESET;
        lockM = LOCK_RESET;
        latchM = 1'b0;
        verify("soft reset");
        wpN <= 1'b1;
        sect_cmd(OP_UNPROT, 2'h1);
        sect_cmd(OP_UNPROT, 2'h2);
        sect_cmd(OP_PROT, 2'h1);
        // cut inside the address: sectors kept, latch still dropped
        host.frame({24'h0, OP_WREN}, 8, rx);
        host.frame({12'h0, OP_UNPROT, 12'h000}, 20, rx);
        repeat (4) @(posedge clk_sys);
        latchM = 1'b0;
        verify("cut sector command");
        wrsr(8'hF0, 1'b1, 1'b1);
        sect_cmd(OP_UNPROT, 2'h3);
        sect_cmd(OP_PROT, 2'h2);
        report_and_stop();
    end
    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end
endmodule // tb_top
